// >>> rtl/sqbcd_decoder.sv
// Notes on behaviour
// - Second byte of a sequence is a no-op while any output is firing.
// - Data byte counts only right after its own unlock byte.
// - Each answer is shifted out during the following frame.
// - Byte after counter unlock is the whole 8-bit counter, MSB first.
// - Counter programming answer is the programmed value unchanged.
// - 0x83 arms low-side test and is echoed.
// - High-side test byte 0x1X; low bits switch high drivers 1a,1b,2a,2b.
// - High-side test answer 0x0X with per-channel high-side status.
// - Low-side test byte 0x2X; low bits switch low drivers 1a,1b,2a,2b.
// - Low-side test answer 0x0X with per-channel low-side status.
// - Integrity byte 0x96 answers 0x69.
// - Codes 0x90 to 0x93 are reserved; master must not send them.
// - 0xC8 reports resistor checks and fire-enable pins in one byte.
// - Current-limit ok bits read 0 on fault, 1 when healthy.
// - Diagnostic resistor ok bit reads 0 on fault, 1 when healthy.
// - Fire-enable status bits follow the present fire-enable pin levels.
// - 0x81 unlocks the second fire-enable counter and is echoed.
// - 0xC8 layout: 1, limit2, limit1, diag, latch2, latch1, fen2, fen1.
module sqbcd_decoder
  import sqbcd_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       spi_clk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_mosi_in,
  output logic            spi_miso_out,
  output logic            spi_miso_oe_out,
  input  wire logic       any_firing_in,
  input  wire logic [3:0] high_drv_test_stat_in,
  input  wire logic [3:0] low_drv_test_stat_in,
  input  wire logic       limit1_ok_in,
  input  wire logic       limit2_ok_in,
  input  wire logic       diag_resistor_ok_in,
  input  wire logic       fen1_latch_in,
  input  wire logic       fen2_latch_in,
  input  wire logic       fire_enable_in_1_in,
  input  wire logic       fire_enable_in_2_in,
  output logic [3:0]      high_drv_on_out,
  output logic [3:0]      low_drv_on_out,
  output logic [7:0]      fire_enable2_count_out,
  output logic            byte_strobe_out
);

  sqbcd_core_s r;
  sqbcd_core_s next_r;
  sqbcd_stat_s stat_pins;
  logic [7:0]  rx_byte;
  logic        rx_new;
  logic [7:0]  cmd;

  // ==========================================================================
  // Functions
  function automatic logic is_reserved(input logic [7:0] b);
    is_reserved = (b >= CMD_RSV_FIRST) && (b <= CMD_RSV_LAST);
  endfunction

  function automatic logic [7:0] test_resp(input logic [3:0] st);
    test_resp = {NIB_TEST_RESP, st};
  endfunction

  // ==========================================================================
  // Link side shifter
  sqbcd_link u_link (
    .spi_clk_in      (spi_clk_in),
    .spi_cs_n_in     (spi_cs_n_in),
    .spi_mosi_in     (spi_mosi_in),
    .resp_in         (r.resp),
    .spi_miso_out    (spi_miso_out),
    .spi_miso_oe_out (spi_miso_oe_out),
    .rx_byte_out     (rx_byte)
  );

  // ==========================================================================
  // Pin gathering
  always_comb
  begin
    stat_pins.high_drv_test_stat = high_drv_test_stat_in;
    stat_pins.low_drv_test_stat  = low_drv_test_stat_in;
    stat_pins.limit2_ok          = limit2_ok_in;
    stat_pins.limit1_ok          = limit1_ok_in;
    stat_pins.diag_resistor_ok   = diag_resistor_ok_in;
    stat_pins.fen2_latch         = fen2_latch_in;
    stat_pins.fen1_latch         = fen1_latch_in;
    stat_pins.fire_enable_in_2   = fire_enable_in_2_in;
    stat_pins.fire_enable_in_1   = fire_enable_in_1_in;
    stat_pins.any_firing         = any_firing_in;
  end

  // Frame end: chip select seen rising after two flip-flops
  assign rx_new = r.cs_sync & ~r.cs_seen;
  assign cmd    = rx_byte;

  // ==========================================================================
  // Command decode
  always_comb
  begin
    next_r             = r;
    next_r.stat_meta   = stat_pins;
    next_r.stat        = r.stat_meta;
    next_r.cs_meta     = spi_cs_n_in;
    next_r.cs_sync     = r.cs_meta;
    next_r.cs_seen     = r.cs_sync;
    next_r.byte_strobe = rx_new;
    if (rx_new)
    begin
      next_r.high_drv_on = DRV_OFF;
      next_r.low_drv_on  = DRV_OFF;
      next_r.unlock      = UNLOCK_NONE;
      next_r.resp        = RESP_NOP;
      if (r.unlock != UNLOCK_NONE)
      begin
        if (!r.stat.any_firing)
        begin
          case (r.unlock)
            UNLOCK_FEN2:
            begin
              next_r.fire_enable2_count = cmd;
              next_r.resp               = cmd;
            end
            UNLOCK_HIGH:
            begin
              if (cmd[7:4] == NIB_HIGH_TEST)
              begin
                next_r.high_drv_on = cmd[3:0];
                next_r.resp        = test_resp(r.stat.high_drv_test_stat);
              end
            end
            UNLOCK_LOW:
            begin
              if (cmd[7:4] == NIB_LOW_TEST)
              begin
                next_r.low_drv_on = cmd[3:0];
                next_r.resp       = test_resp(r.stat.low_drv_test_stat);
              end
            end
            default:
            begin
              next_r.resp = RESP_NOP;
            end
          endcase
        end
      end
      else if (is_reserved(cmd))
      begin
        next_r.resp = RESP_NOP;
      end
      else
      begin
        case (cmd)
          CMD_UNLOCK_FEN2:
          begin
            next_r.unlock = UNLOCK_FEN2;
            next_r.resp   = cmd;
          end
          CMD_UNLOCK_HIGH:
          begin
            next_r.unlock = UNLOCK_HIGH;
            next_r.resp   = cmd;
          end
          CMD_UNLOCK_LOW:
          begin
            next_r.unlock = UNLOCK_LOW;
            next_r.resp   = cmd;
          end
          CMD_INTEGRITY:
          begin
            next_r.resp = RESP_INTEGRITY;
          end
          CMD_REF_STATUS:
          begin
            next_r.resp = {REF_TOP_BIT,
                           r.stat.limit2_ok,
                           r.stat.limit1_ok,
                           r.stat.diag_resistor_ok,
                           r.stat.fen2_latch,
                           r.stat.fen1_latch,
                           r.stat.fire_enable_in_2,
                           r.stat.fire_enable_in_1};
          end
          default:
          begin
            next_r.resp = RESP_NOP;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      r                    <= '0;
      r.unlock             <= UNLOCK_NONE;
      r.resp               <= RESP_NOP;
      r.fire_enable2_count <= COUNT2_RESET;
      r.cs_meta            <= CS_IDLE;
      r.cs_sync            <= CS_IDLE;
      r.cs_seen            <= CS_IDLE;
      r.high_drv_on        <= DRV_OFF;
      r.low_drv_on         <= DRV_OFF;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign high_drv_on_out        = r.high_drv_on;
  assign low_drv_on_out         = r.low_drv_on;
  assign fire_enable2_count_out = r.fire_enable2_count;
  assign byte_strobe_out        = r.byte_strobe;

endmodule

// >>> rtl/sqbcd_link.sv
module sqbcd_link
  import sqbcd_pkg::*;
(
  input  wire logic       spi_clk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_mosi_in,
  input  wire logic [7:0] resp_in,
  output logic            spi_miso_out,
  output logic            spi_miso_oe_out,
  output logic [7:0]      rx_byte_out
);

  sqbcd_link_s r;
  sqbcd_link_s next_r;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;

  // ==========================================================================
  // Shift in MSB first, shift the pending answer out
  always_comb
  begin
    next_r       = r;
    next_bit_cnt = bit_cnt;
    if (!spi_cs_n_in)
    begin
      next_bit_cnt    = bit_cnt + 3'h1;
      next_r.rx_shift = {r.rx_shift[6:0], spi_mosi_in};
      if (bit_cnt == BIT_FIRST)
        next_r.tx_shift = {resp_in[6:0], 1'b0};
      else
        next_r.tx_shift = {r.tx_shift[6:0], 1'b0};
      if (bit_cnt == BIT_LAST)
        next_r.rx_byte = {r.rx_shift[6:0], spi_mosi_in};
    end
  end

  // Bit counter restarts whenever the chip select is released
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in)
  begin
    if (spi_cs_n_in)
      bit_cnt <= BIT_FIRST;
    else
      bit_cnt <= next_bit_cnt;
  end

  always_ff @(posedge spi_clk_in)
  begin
    r <= next_r;
  end

  assign spi_miso_out    = (bit_cnt == BIT_FIRST) ? resp_in[7] : r.tx_shift[7];
  assign spi_miso_oe_out = ~spi_cs_n_in;
  assign rx_byte_out     = r.rx_byte;

endmodule

// >>> rtl/sqbcd_pkg.sv
package sqbcd_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_UNLOCK_FEN2 = 8'h81;
  localparam logic [7:0] CMD_UNLOCK_HIGH = 8'h82;
  localparam logic [7:0] CMD_UNLOCK_LOW  = 8'h83;
  localparam logic [7:0] CMD_RSV_FIRST   = 8'h90;
  localparam logic [7:0] CMD_RSV_LAST    = 8'h93;
  localparam logic [7:0] CMD_INTEGRITY   = 8'h96;
  localparam logic [7:0] CMD_REF_STATUS  = 8'hC8;

  // ==========================================================================
  // Field layouts and fixed answers
  localparam logic [3:0] NIB_HIGH_TEST   = 4'h1;
  localparam logic [3:0] NIB_LOW_TEST    = 4'h2;
  localparam logic [3:0] NIB_TEST_RESP   = 4'h0;
  localparam logic [7:0] RESP_NOP        = 8'h00;
  localparam logic [7:0] RESP_INTEGRITY  = 8'h69;
  localparam logic       REF_TOP_BIT     = 1'b1;
  localparam logic [7:0] COUNT2_RESET    = 8'h00;
  localparam logic       CS_IDLE         = 1'b1;
  localparam logic [3:0] DRV_OFF         = 4'h0;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [2:0] BIT_FIRST       = 3'h0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    UNLOCK_NONE,
    UNLOCK_FEN2,
    UNLOCK_HIGH,
    UNLOCK_LOW
  } sqbcd_unlock_e;

  // Analog and pin status, channel order 1a,1b,2a,2b from bit 0
  typedef struct packed {
    logic [3:0] high_drv_test_stat;
    logic [3:0] low_drv_test_stat;
    logic       limit2_ok;
    logic       limit1_ok;
    logic       diag_resistor_ok;
    logic       fen2_latch;
    logic       fen1_latch;
    logic       fire_enable_in_2;
    logic       fire_enable_in_1;
    logic       any_firing;
  } sqbcd_stat_s;

  // Link-side shifter state
  typedef struct packed {
    logic [7:0] rx_shift;
    logic [7:0] rx_byte;
    logic [7:0] tx_shift;
  } sqbcd_link_s;

  // Decoder state
  typedef struct packed {
    sqbcd_stat_s   stat_meta;
    sqbcd_stat_s   stat;
    logic          cs_meta;
    logic          cs_sync;
    logic          cs_seen;
    sqbcd_unlock_e unlock;
    logic [7:0]    resp;
    logic [7:0]    fire_enable2_count;
    logic [3:0]    high_drv_on;
    logic [3:0]    low_drv_on;
    logic          byte_strobe;
  } sqbcd_core_s;

endpackage

// >>> testbench/sqbcd_decoder_asserts.sv
module sqbcd_decoder_asserts
  import sqbcd_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       sys_rst_in,
  input wire logic       spi_cs_n_in,
  input wire logic       spi_miso_oe_out,
  input wire logic       any_firing_in,
  input wire logic [3:0] high_drv_on_out,
  input wire logic [3:0] low_drv_on_out,
  input wire logic [7:0] fire_enable2_count_out,
  input wire logic       byte_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  // ==========================================================================
  // Firing long enough to reach the decoder
  sequence s_firing;
    any_firing_in[*5];
  endsequence
  a_strobe_pulse: assert property (byte_strobe_out |=> !byte_strobe_out)
    else $error("strobe too long");
  a_count_hold: assert property (!byte_strobe_out |-> $stable(fire_enable2_count_out))
    else $error("count moved without a byte");
  a_drv_hold: assert property (!byte_strobe_out |->
    $stable({high_drv_on_out, low_drv_on_out}))
    else $error("drivers moved without a byte");
  a_drv_reset: assert property (disable iff (1'b0) sys_rst_in |=>
    high_drv_on_out == DRV_OFF && low_drv_on_out == DRV_OFF
    && fire_enable2_count_out == COUNT2_RESET)
    else $error("reset values wrong");
  a_one_side: assert property (!((|high_drv_on_out) && (|low_drv_on_out)))
    else $error("both driver sides on");
  a_fire_count: assert property (s_firing |=> $stable(fire_enable2_count_out))
    else $error("count changed while firing");
  a_fire_drv: assert property (s_firing |=>
    (high_drv_on_out & ~$past(high_drv_on_out)) == DRV_OFF
    && (low_drv_on_out & ~$past(low_drv_on_out)) == DRV_OFF)
    else $error("driver armed while firing");
  a_oe_cs: assert property (spi_miso_oe_out == !spi_cs_n_in)
    else $error("miso enable wrong");
endmodule
bind sqbcd_decoder sqbcd_decoder_asserts sqbcd_decoder_asserts_i (
  .clock_in              (clock_in),
  .sys_rst_in            (sys_rst_in),
  .spi_cs_n_in           (spi_cs_n_in),
  .spi_miso_oe_out       (spi_miso_oe_out),
  .any_firing_in         (any_firing_in),
  .high_drv_on_out       (high_drv_on_out),
  .low_drv_on_out        (low_drv_on_out),
  .fire_enable2_count_out(fire_enable2_count_out),
  .byte_strobe_out       (byte_strobe_out)
);

// >>> testbench/sqbcd_master.sv
module sqbcd_master (
  output logic     spi_clk_out,
  output logic     spi_cs_n_out,
  output logic     spi_mosi_out,
  input wire logic spi_miso_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end
  // ==========================================================================
  // One frame; answer of the previous byte comes back, gap keeps spacing
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int gap);
    spi_cs_n_out = 1'b0;
    spi_mosi_out = tx[7];
    #6;
    for (int i = 7; i >= 0; i--)
    begin
      rx[i] = spi_miso_in;
      spi_clk_out = 1'b1;
      #6;
      spi_clk_out = 1'b0;
      if (i > 0)
        spi_mosi_out = tx[i-1];
      #6;
    end
    spi_cs_n_out = 1'b1;
    spi_mosi_out = ~tx[0];
    #gap;
  endtask
endmodule

// >>> testbench/squib_spi_command_decoder_test.sv
module squib_spi_command_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sqbcd_pkg::*;
  logic       clock_in, sys_rst_in, fire;
  logic [3:0] hs, ls;
  logic [6:0] st;
  wire        sck, cs_n, mosi, miso, oe, strobe;
  wire  [3:0] hi_on, lo_on;
  wire  [7:0] cnt;
  int         err_total, checks, gap;
  sqbcd_master sqbcd_master_i (.spi_clk_out(sck), .spi_cs_n_out(cs_n),
    .spi_mosi_out(mosi), .spi_miso_in(miso));
  sqbcd_decoder sqbcd_decoder_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .spi_clk_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_out(oe), .any_firing_in(fire), .high_drv_test_stat_in(hs),
    .low_drv_test_stat_in(ls), .limit2_ok_in(st[6]), .limit1_ok_in(st[5]),
    .diag_resistor_ok_in(st[4]), .fen2_latch_in(st[3]), .fen1_latch_in(st[2]),
    .fire_enable_in_2_in(st[1]), .fire_enable_in_1_in(st[0]),
    .high_drv_on_out(hi_on), .low_drv_on_out(lo_on),
    .fire_enable2_count_out(cnt), .byte_strobe_out(strobe));
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // ==========================================================================
  // Shared helpers
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    if (got !== exp)
      err_total++;
  endtask
  task sx(input logic [7:0] tx, input logic [7:0] exp);
    logic [7:0] rx;
    sqbcd_master_i.xfer(tx, rx, gap);
    chk(rx, exp);
  endtask
  task at_edge;
    @(posedge clock_in);
    #1;
  endtask
  task stop_test;
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task t_integrity;
    sx(CMD_INTEGRITY, 8'h00);
    sx(8'h00, RESP_INTEGRITY);
  endtask
  task t_count;
    sx(CMD_UNLOCK_FEN2, 8'h00);
    sx(8'hA5, CMD_UNLOCK_FEN2);
    chk(cnt, 8'hA5);
    sx(CMD_UNLOCK_FEN2, 8'hA5);
    sx(8'h5A, CMD_UNLOCK_FEN2);
    sx(8'h3C, 8'h5A);
    chk(cnt, 8'h5A);
    sx(8'h00, 8'h00);
  endtask
  task t_high;
    at_edge();
    hs = 4'hA;
    sx(CMD_UNLOCK_HIGH, 8'h00);
    sx(8'h15, CMD_UNLOCK_HIGH);
    chk({hi_on, lo_on}, 8'h50);
    sx(CMD_UNLOCK_HIGH, 8'h0A);
    chk({hi_on, lo_on}, 8'h00);
    sx(8'h25, CMD_UNLOCK_HIGH);
    chk({hi_on, lo_on}, 8'h00);
    sx(8'h00, 8'h00);
    sx(CMD_UNLOCK_HIGH, 8'h00);
    sx(CMD_INTEGRITY, CMD_UNLOCK_HIGH);
    sx(8'h1F, 8'h00);
    chk({hi_on, lo_on}, 8'h00);
    sx(8'h00, 8'h00);
  endtask
  task t_low;
    gap = 2000;
    at_edge();
    ls = 4'h6;
    sx(CMD_UNLOCK_LOW, 8'h00);
    sx(8'h2C, CMD_UNLOCK_LOW);
    chk({hi_on, lo_on}, 8'h0C);
    sx(8'h00, 8'h06);
    gap = 400;
  endtask
  task t_fire;
    at_edge();
    fire = 1'b1;
    sx(CMD_UNLOCK_FEN2, 8'h00);
    sx(8'h33, CMD_UNLOCK_FEN2);
    chk(cnt, 8'h5A);
    sx(CMD_UNLOCK_HIGH, 8'h00);
    sx(8'h1F, CMD_UNLOCK_HIGH);
    chk({hi_on, lo_on}, 8'h00);
    at_edge();
    fire = 1'b0;
    sx(8'h00, 8'h00);
  endtask
  task t_status;
    logic [6:0] pats[4];
    pats = '{7'h7F, 7'h00, 7'h55, 7'h2A};
    foreach (pats[i])
    begin
      at_edge();
      st = pats[i];
      sx(CMD_REF_STATUS, 8'h00);
      sx(8'h00, {REF_TOP_BIT, st});
    end
  endtask
  // ==========================================================================
  // Main sequence and watchdog (34 frames of under 3 us each)
  initial
  begin
    sys_rst_in = 1'b1;
    fire = 1'b0;
    hs = 4'h0;
    ls = 4'h0;
    st = 7'h7F;
    err_total = 0;
    checks = 0;
    gap = 400;
    repeat (12) @(posedge clock_in);
    #1 sys_rst_in = 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    sx(8'h00, RESP_NOP);
    t_integrity();
    t_count();
    t_high();
    t_low();
    t_fire();
    t_status();
    stop_test();
  end
  initial
  begin
    #200us;
    err_total++;
    stop_test();
  end
endmodule
